// file: common/tmr_pkg.sv
// Purpose: shared constants and carrier types for the temperature register bank
// Assumes: byte-wide register port presented by the serial-bus protocol engine
// Notes: mirrored addresses share one storage element

package tmr_pkg;

   localparam int TMR_NUM_RW = 15;

   // byte addresses of read-only data, status and trigger registers
   localparam logic [7:0] TMR_INT_TEMP_INT = 8'h00;
   localparam logic [7:0] TMR_INT_TEMP_INT_M = 8'h38;
   localparam logic [7:0] TMR_EXT_TEMP_INT = 8'h01;
   localparam logic [7:0] TMR_EXT_TEMP_INT_M = 8'h3a;
   localparam logic [7:0] TMR_INT_TEMP_FRAC = 8'h29;
   localparam logic [7:0] TMR_INT_TEMP_FRAC_M = 8'h39;
   localparam logic [7:0] TMR_EXT_TEMP_FRAC = 8'h10;
   localparam logic [7:0] TMR_EXT_TEMP_FRAC_M = 8'h3b;
   localparam logic [7:0] TMR_CHAN_STATUS_A = 8'h02;
   localparam logic [7:0] TMR_MAIN_STATUS = 8'h34;
   localparam logic [7:0] TMR_HIGH_FLAGS = 8'h35;
   localparam logic [7:0] TMR_LOW_FLAGS = 8'h36;
   localparam logic [7:0] TMR_FAULT_FLAGS = 8'h1b;
   localparam logic [7:0] TMR_SINGLE_UPDATE = 8'h0f;

   // fractional data uses only the top three bits; the rest read as zero
   localparam logic [7:0] TMR_FRAC_MASK = 8'he0;
   localparam logic [7:0] TMR_ZERO = 8'h00;

   // index of each read-write register inside the storage array
   localparam int TMR_I_CONFIG = 0;
   localparam int TMR_I_RATE = 1;
   localparam int TMR_I_INT_HI = 2;
   localparam int TMR_I_INT_LO = 3;
   localparam int TMR_I_EXT_HI = 4;
   localparam int TMR_I_EXT_LO = 5;
   localparam int TMR_I_EXT_HI_FRAC = 6;
   localparam int TMR_I_EXT_LO_FRAC = 7;
   localparam int TMR_I_EXT_CRIT = 8;
   localparam int TMR_I_INT_CRIT = 9;
   localparam int TMR_I_HYST = 10;
   localparam int TMR_I_REPEAT = 11;
   localparam int TMR_I_BETA = 12;
   localparam int TMR_I_IDEAL = 13;
   localparam int TMR_I_CHAN_MASK = 14;

   // primary address, mirror address (same as primary when none), reset value
   localparam logic [7:0] TMR_RW_ADDR_A [TMR_NUM_RW] = '{
      8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h13, 8'h14,
      8'h19, 8'h20, 8'h21, 8'h22, 8'h25, 8'h27, 8'h1f};
   localparam logic [7:0] TMR_RW_ADDR_B [TMR_NUM_RW] = '{
      8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h13, 8'h14,
      8'h19, 8'h20, 8'h21, 8'h22, 8'h25, 8'h27, 8'h1f};
   localparam logic [7:0] TMR_RW_RESET [TMR_NUM_RW] = '{
      8'h00, 8'h06, 8'h55, 8'h80, 8'h55, 8'h80, 8'h00, 8'h00,
      8'h64, 8'h64, 8'h0a, 8'h70, 8'h10, 8'h12, 8'h00};

   // measurement results delivered by the conversion engine
   typedef struct packed {
      logic [7:0] int_temp_int;
      logic [7:0] int_temp_frac;
      logic [7:0] ext_temp_int;
      logic [7:0] ext_temp_frac;
   } tmr_meas_t;

   // hardware events that set sticky flags
   typedef struct packed {
      logic [7:0] main_set;
      logic [7:0] high_set;
      logic [7:0] low_set;
      logic [7:0] fault_set;
   } tmr_event_t;

   // settings handed to the measurement and limit logic
   typedef struct packed {
      logic [7:0] general_config;
      logic [7:0] update_rate;
      logic [7:0] internal_high_limit;
      logic [7:0] internal_low_limit;
      logic [7:0] external_high_limit_int;
      logic [7:0] external_low_limit_int;
      logic [7:0] external_high_limit_frac;
      logic [7:0] external_low_limit_frac;
      logic [7:0] external_critical_limit;
      logic [7:0] internal_critical_limit;
      logic [7:0] critical_hysteresis;
      logic [7:0] repeat_count_control;
      logic [7:0] external_beta_config;
      logic [7:0] external_ideality;
      logic [7:0] channel_mask;
   } tmr_cfg_t;

endpackage : tmr_pkg

// file: hw/tmr_regbank.sv
// Purpose: temperature monitor register bank behind the serial-bus register port
// Assumes: protocol engine gives one-cycle read and write strobes with a byte address
// Notes: read data is registered and valid one cycle after the read strobe
// Function
// - every register is reached by its byte address through the serial-bus register port
// - unused bits and unmapped addresses always read back as zero
// - internal integer temperature, read-only at 00h and 38h, resets zero
// - external integer temperature, read-only at 01h and 3Ah, resets zero
// - channel status readable at 02h and at 34h, resets zero
// - general configuration read-write at 03h and 09h, shared, resets zero
// - update rate read-write at 0Ah and 04h, resets 06h
// - internal low limit at 06h/0Ch resets 80h; internal high at 05h/0Bh
// - external high limit integer at 07h/0Dh, resets 55h
// - external low limit integer at 0Eh/08h, resets 80h
// - any write to 0Fh starts one single measurement update
// - external limit fractional bytes at 13h and 14h reset zero
// - critical limits at 19h external and 20h internal reset 64h
// - external fault flags at 1Bh, reset zero, cleared by reading
// - one hysteresis register at 21h, reset 0Ah, for all critical limits
// - repeat count control at 22h resets 70h, sets alert persistence
// - external beta settings read-write at 25h, reset 10h
// - external ideality read-write at 27h, reset 12h
// - internal fraction at 29h/39h, external fraction at 10h, read-only
// - main status at 34h collects channel flags and clears on read
// - high flags at 35h, low flags at 36h, reset zero, clear on read
// - reading an integer byte freezes that channel's fraction for later read

`timescale 1ns/1ps

module tmr_regbank
   import tmr_pkg::*;
(
   input wire logic clk, // 10 MHz device clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire logic [7:0] reg_addr, // register byte address from bus engine
   input wire logic reg_wr, // one-cycle write strobe
   input wire logic [7:0] reg_wdata, // write data byte
   input wire logic reg_rd, // one-cycle read strobe
   output logic [7:0] reg_rdata, // read data, valid cycle after reg_rd
   input wire logic meas_valid, // one-cycle strobe: new results present
   input wire tmr_pkg::tmr_meas_t meas, // new measurement results
   input wire tmr_pkg::tmr_event_t events, // flag set pulses, level per bit
   output tmr_pkg::tmr_cfg_t cfg, // current settings
   output logic single_update // one-cycle pulse starting a single update
);
   import tmr_pkg::*;

   logic [7:0] rw_q [TMR_NUM_RW];
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic oneshot_q;
   tmr_meas_t data_q;
   logic [7:0] int_frac_shadow_q;
   logic [7:0] ext_frac_shadow_q;
   logic [7:0] main_q;
   logic [7:0] high_q;
   logic [7:0] low_q;
   logic [7:0] fault_q;

   // address decode for the read-only, read-to-clear and trigger locations
   wire rd_int_int = reg_rd && (reg_addr == TMR_INT_TEMP_INT || reg_addr == TMR_INT_TEMP_INT_M);
   wire rd_ext_int = reg_rd && (reg_addr == TMR_EXT_TEMP_INT || reg_addr == TMR_EXT_TEMP_INT_M);
   wire rd_main = reg_rd && (reg_addr == TMR_MAIN_STATUS || reg_addr == TMR_CHAN_STATUS_A);
   wire rd_high = reg_rd && (reg_addr == TMR_HIGH_FLAGS);
   wire rd_low = reg_rd && (reg_addr == TMR_LOW_FLAGS);
   wire rd_fault = reg_rd && (reg_addr == TMR_FAULT_FLAGS);
   wire wr_oneshot = reg_wr && (reg_addr == TMR_SINGLE_UPDATE);

   // read-write storage: both addresses of a pair hit one flop set
   genvar gi;
   generate
      for (gi = 0; gi < TMR_NUM_RW; gi++)
      begin : g_rw
         wire hit_w = reg_wr && (reg_addr == TMR_RW_ADDR_A[gi]
                                 || reg_addr == TMR_RW_ADDR_B[gi]);
         always_ff @(posedge clk or negedge arst_n)
         begin
            if (!arst_n)
               rw_q[gi] <= TMR_RW_RESET[gi];
            else if (hit_w)
               rw_q[gi] <= reg_wdata;
         end
      end
   endgenerate

   // settings out to the measurement side
   assign cfg.general_config = rw_q[TMR_I_CONFIG];
   assign cfg.update_rate = rw_q[TMR_I_RATE];
   assign cfg.internal_high_limit = rw_q[TMR_I_INT_HI];
   assign cfg.internal_low_limit = rw_q[TMR_I_INT_LO];
   assign cfg.external_high_limit_int = rw_q[TMR_I_EXT_HI];
   assign cfg.external_low_limit_int = rw_q[TMR_I_EXT_LO];
   assign cfg.external_high_limit_frac = rw_q[TMR_I_EXT_HI_FRAC];
   assign cfg.external_low_limit_frac = rw_q[TMR_I_EXT_LO_FRAC];
   assign cfg.external_critical_limit = rw_q[TMR_I_EXT_CRIT];
   assign cfg.internal_critical_limit = rw_q[TMR_I_INT_CRIT];
   assign cfg.critical_hysteresis = rw_q[TMR_I_HYST];
   assign cfg.repeat_count_control = rw_q[TMR_I_REPEAT];
   assign cfg.external_beta_config = rw_q[TMR_I_BETA];
   assign cfg.external_ideality = rw_q[TMR_I_IDEAL];
   assign cfg.channel_mask = rw_q[TMR_I_CHAN_MASK];

   // one-shot trigger: the written value is not stored, any value fires
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         oneshot_q <= 1'b0;
      else
         oneshot_q <= wr_oneshot;
   end
   assign single_update = oneshot_q;

   // measurement results; unused fraction bits are dropped here once
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         data_q <= '0;
      else if (meas_valid)
      begin
         data_q.int_temp_int <= meas.int_temp_int;
         data_q.ext_temp_int <= meas.ext_temp_int;
         data_q.int_temp_frac <= meas.int_temp_frac & TMR_FRAC_MASK;
         data_q.ext_temp_frac <= meas.ext_temp_frac & TMR_FRAC_MASK;
      end
   end

   // fraction shadows: frozen on an integer read so a pair stays coherent
   // even when a new result lands between the two host reads
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         int_frac_shadow_q <= TMR_ZERO;
         ext_frac_shadow_q <= TMR_ZERO;
      end
      else
      begin
         if (rd_int_int)
            int_frac_shadow_q <= data_q.int_temp_frac;
         if (rd_ext_int)
            ext_frac_shadow_q <= data_q.ext_temp_frac;
      end
   end

   // sticky flags: a set arriving with the clearing read survives
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         main_q <= TMR_ZERO;
         high_q <= TMR_ZERO;
         low_q <= TMR_ZERO;
         fault_q <= TMR_ZERO;
      end
      else
      begin
         main_q <= (rd_main ? TMR_ZERO : main_q) | events.main_set;
         high_q <= (rd_high ? TMR_ZERO : high_q) | events.high_set;
         low_q <= (rd_low ? TMR_ZERO : low_q) | events.low_set;
         fault_q <= (rd_fault ? TMR_ZERO : fault_q) | events.fault_set;
      end
   end

   // read mux; anything not decoded returns zero
   always_comb
   begin
      rdata_d = TMR_ZERO;
      if (reg_addr == TMR_INT_TEMP_INT || reg_addr == TMR_INT_TEMP_INT_M)
         rdata_d = data_q.int_temp_int;
      else if (reg_addr == TMR_EXT_TEMP_INT || reg_addr == TMR_EXT_TEMP_INT_M)
         rdata_d = data_q.ext_temp_int;
      else if (reg_addr == TMR_INT_TEMP_FRAC || reg_addr == TMR_INT_TEMP_FRAC_M)
         rdata_d = int_frac_shadow_q;
      else if (reg_addr == TMR_EXT_TEMP_FRAC || reg_addr == TMR_EXT_TEMP_FRAC_M)
         rdata_d = ext_frac_shadow_q;
      else if (reg_addr == TMR_MAIN_STATUS || reg_addr == TMR_CHAN_STATUS_A)
         rdata_d = main_q;
      else if (reg_addr == TMR_HIGH_FLAGS)
         rdata_d = high_q;
      else if (reg_addr == TMR_LOW_FLAGS)
         rdata_d = low_q;
      else if (reg_addr == TMR_FAULT_FLAGS)
         rdata_d = fault_q;
      else
      begin
         for (int i = 0; i < TMR_NUM_RW; i++)
         begin
            if (reg_addr == TMR_RW_ADDR_A[i] || reg_addr == TMR_RW_ADDR_B[i])
               rdata_d = rw_q[i];
         end
      end
   end

   // read data holds until the next read strobe
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata_q <= TMR_ZERO;
      else if (reg_rd)
         rdata_q <= rdata_d;
   end
   assign reg_rdata = rdata_q;

endmodule : tmr_regbank

// file: verification/tmr_regbank_props.sv
// Purpose: port assertions for the temperature register bank
// Assumes: one-cycle strobes, read data one cycle after reg_rd
// Notes: bound onto every tmr_regbank instance
`timescale 1ns/1ps
module tmr_regbank_props
   import tmr_pkg::*;
(
   input wire logic clk, // device clock
   input wire logic arst_n, // reset, active low
   input wire logic [7:0] reg_addr, // register address
   input wire logic reg_wr, // write strobe
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_rd, // read strobe
   input wire logic [7:0] reg_rdata, // read data
   input wire tmr_pkg::tmr_cfg_t cfg, // settings
   input wire logic single_update // one-shot pulse
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // trigger, read data and settings against their causes
   property p_shot; reg_wr && reg_addr == 8'h0f |=> single_update; endproperty
   property p_cause; single_update |-> $past(reg_wr) && $past(reg_addr) == 8'h0f; endproperty
   property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
   property p_cfg;
      reg_wr && (reg_addr == 8'h03 || reg_addr == 8'h09) |=> cfg.general_config == $past(reg_wdata);
   endproperty
   property p_rate; reg_wr && reg_addr == 8'h04 |=> cfg.update_rate == $past(reg_wdata); endproperty
   property p_ro; reg_wr && reg_addr == 8'h00 |=> $stable(cfg); endproperty
   property p_zero; reg_rd && (reg_addr == 8'h0f || reg_addr == 8'hff) |=> reg_rdata == 8'h00;
   endproperty
   property p_frac; reg_rd && (reg_addr == 8'h29 || reg_addr == 8'h10) |=> reg_rdata[4:0] == 5'h00;
   endproperty
   a_shot: assert property (p_shot) else $error("no pulse after trigger write");
   a_cause: assert property (p_cause) else $error("pulse without trigger write");
   a_hold: assert property (p_hold) else $error("read data moved without read");
   a_cfg: assert property (p_cfg) else $error("config write lost");
   a_rate: assert property (p_rate) else $error("rate mirror write lost");
   a_ro: assert property (p_ro) else $error("read-only write changed settings");
   a_zero: assert property (p_zero) else $error("unreadable place not zero");
   a_frac: assert property (p_frac) else $error("unused fraction bits set");
   c_shot: cover property (single_update);
   c_rate: cover property (reg_wr && reg_addr == 8'h04);
   c_frac: cover property (reg_rd && reg_addr == 8'h29);
endmodule : tmr_regbank_props

bind tmr_regbank tmr_regbank_props props_u (.clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata,
   .reg_rd, .reg_rdata, .cfg, .single_update);

// file: verification/tmr_host.sv
// Purpose: register-port host standing in for the serial-bus engine
// Assumes: one strobe cycle per access, read data one cycle later
// Notes: released lines show the inverse so a stale value never passes
`timescale 1ns/1ps
module tmr_host (
   input wire logic clk, // device clock
   output logic [7:0] reg_addr, // register address
   output logic reg_wr, // write strobe
   output logic [7:0] reg_wdata, // write data
   output logic reg_rd, // read strobe
   input wire logic [7:0] reg_rdata // read data
);
   // idle port at time zero
   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // one write; the strobe covers exactly one rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
      reg_addr = ~a;
   endtask : wr
   // one read; data taken a cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
endmodule : tmr_host

// file: verification/temp_monitor_register_bank_test.sv
// Purpose: self-checking bench for the temperature register bank
// Assumes: host model drives the register port off the falling edge
// Notes: fixed seed keeps the random data repeatable
`timescale 1ns/1ps
module temp_monitor_register_bank_test;
   import tmr_pkg::*;
   logic clk, arst_n, meas_valid, single_update, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   tmr_meas_t meas, m0, m1;
   tmr_event_t events;
   tmr_cfg_t cfg;
   int failures, compares, seed;
   localparam logic [7:0] rst_val [15] = '{8'h00, 8'h06, 8'h55, 8'h80, 8'h55, 8'h80, 8'h00,
      8'h00, 8'h64, 8'h64, 8'h0a, 8'h70, 8'h10, 8'h12, 8'h00};
   localparam logic [7:0] flag_a [4] = '{8'h02, 8'h35, 8'h36, 8'h1b};
   localparam logic [7:0] flag_b [4] = '{8'h34, 8'h35, 8'h36, 8'h1b};
   tmr_regbank dut_u (.clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
      .meas_valid, .meas, .events, .cfg, .single_update);
   tmr_host host_u (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host_u.rd(a, d);
      chk(d, exp);
   endtask : rchk
   // new results from the conversion side, one strobe cycle
   task automatic load(output tmr_meas_t x);
      x = tmr_meas_t'($random(seed));
      @(negedge clk);
      meas = x;
      meas_valid = 1'b1;
      @(negedge clk);
      meas_valid = 1'b0;
   endtask : load
   task automatic end_sim;
      $display("counts: %0d compares, %0d failures", compares, failures);
      if (failures == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   // main sequence
   initial
   begin
      seed = 32'h617ed97b;
      arst_n = 1'b0;
      meas_valid = 1'b0;
      meas = '0;
      events = '0;
      repeat (4) @(posedge clk);
      @(negedge clk) arst_n = 1'b1;
      for (int i = 0; i < TMR_NUM_RW; i++)
      begin
         chk(cfg[8*(14-i) +: 8], rst_val[i]);
         rchk(TMR_RW_ADDR_A[i], rst_val[i]);
         rchk(TMR_RW_ADDR_B[i], rst_val[i]);
      end
      $display("test reset done");
      for (int i = 0; i < TMR_NUM_RW; i++)
      begin
         v = 8'($random(seed));
         host_u.wr(TMR_RW_ADDR_B[i], v);
         rchk(TMR_RW_ADDR_A[i], v);
         chk(cfg[8*(14-i) +: 8], v);
      end
      $display("test mirror done");
      host_u.wr(TMR_INT_TEMP_INT, 8'h5a);
      rchk(TMR_INT_TEMP_INT, 8'h00);
      rchk(8'hff, 8'h00);
      host_u.wr(TMR_SINGLE_UPDATE, 8'h00);
      chk({7'h00, single_update}, 8'h01);
      @(negedge clk);
      chk({7'h00, single_update}, 8'h00);
      rchk(TMR_SINGLE_UPDATE, 8'h00);
      $display("test trigger done");
      load(m0);
      rchk(TMR_INT_TEMP_INT, m0.int_temp_int);
      rchk(TMR_EXT_TEMP_INT_M, m0.ext_temp_int);
      load(m1);
      rchk(TMR_INT_TEMP_FRAC_M, m0.int_temp_frac & 8'he0);
      rchk(TMR_EXT_TEMP_FRAC, m0.ext_temp_frac & 8'he0);
      rchk(TMR_INT_TEMP_INT_M, m1.int_temp_int);
      rchk(TMR_INT_TEMP_FRAC, m1.int_temp_frac & 8'he0);
      $display("test data done");
      for (int k = 0; k < 4; k++)
      begin
         v = 8'($random(seed)) | 8'h01;
         @(negedge clk);
         events = tmr_event_t'(32'(v) << (8 * (3 - k)));
         @(negedge clk);
         events = '0;
         rchk(flag_a[k], v);
         rchk(flag_b[k], 8'h00);
      end
      // a set landing in the clearing read's cycle must survive that read
      fork
         host_u.rd(TMR_HIGH_FLAGS, v);
         begin
            @(negedge clk);
            events.high_set = 8'h80;
            @(negedge clk);
            events = '0;
         end
      join
      chk(v, 8'h00);
      rchk(TMR_HIGH_FLAGS, 8'h80);
      $display("test flags done");
      end_sim;
   end
   // watchdog: the run needs well under a thousand cycles
   initial
   begin
      #200_000;
      failures++;
      end_sim;
   end
endmodule : temp_monitor_register_bank_test
